// ---- logic/lcd_config_defs.svh ----
`ifndef LCD_CONFIG_DEFS_SVH
`define LCD_CONFIG_DEFS_SVH
// Overview of operation
// - Source bit 0 external reference, 1 bus clock
// - Divide-by-sixteen and adjust field make base clock
// - Charge pump enable bit turns pump on
// - Pump mode doubler/tripler, ignored on internal supply
// - Bypass bit 0 buffered, 1 unbuffered
// - Supply select 01 powers internally, third bias
// - Wait-mode bit 0 keeps LCD on in wait
// - Deep-stop bit 1 turns LCD off in stop
// - Duty field 10 selects three backplanes
// - Frame clock field selects frame frequency
// - Blink mode 0 selected segments, 1 all
// - Blink rate field divides base frequency
// - One enable bit per frontplane pin, six registers
// - Pump clock adjust field selects pump clock
// - Supply select 10 means external LCD supply pin

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_CLOCK_SELECT     4'h0
`define OFS_SUPPLY_CONTROL   4'h1
`define OFS_LOW_POWER        4'h2
`define OFS_FRAME_CONTROL    4'h3
`define OFS_BLINK_CONTROL    4'h4
`define OFS_FRONTPLANE_BASE  4'h5
`define FRONTPLANE_REGS      6
`define REG_RESET            8'h00

// ----------------------------------------------------------------
// Field encodings
// ----------------------------------------------------------------
`define SUPPLY_INTERNAL      2'h1
`define SUPPLY_EXTERNAL      2'h2
`define DUTY_THIRD           2'h2
`define BLINK_RATE_SHIFT     4'h4
`define LOW_POWER_MASK       8'h03
`define FRAME_MASK           8'h3F
`define BLINK_MASK           8'h8F
`endif

// ---- logic/lcd_config_pkg.sv ----
package lcd_config_pkg;
  // Whole state of the configuration block
  typedef struct packed {
    logic [7:0]  clock_select;
    logic [7:0]  supply_control;
    logic [7:0]  low_power;
    logic [7:0]  frame_control;
    logic [7:0]  blink_control;
    logic [47:0] frontplane_enable;
    logic [7:0]  read_data;
    logic [2:0]  ext_sync;
    logic [1:0]  wait_sync;
    logic [1:0]  stop_sync;
    logic [9:0]  prescale_count;
    logic        base_tick;
    logic [6:0]  frame_count;
    logic [1:0]  backplane;
    logic        frame_start;
    logic [11:0] blink_count;
    logic        blink_blank;
  } lcd_state_type;
endpackage

// ---- logic/lcd_config.sv ----
`timescale 1ns/100ps
`include "lcd_config_defs.svh"
module lcd_config
  import lcd_config_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  input  wire logic        ext_clk_ref,
  input  wire logic        wait_mode,
  input  wire logic        deep_stop_mode,
  output logic             lcd_active,
  output logic             charge_pump_on,
  output logic             pump_tripler,
  output logic      [1:0]  pump_clock_adjust,
  output logic             buffer_bypass,
  output logic             supply_internal,
  output logic             supply_external,
  output logic             high_drive_buffer,
  output logic             low_power_wave,
  output logic      [1:0]  duty_select,
  output logic      [1:0]  backplane_index,
  output logic             frame_start,
  output logic             base_tick,
  output logic             blank_all,
  output logic             blank_selected,
  output logic      [47:0] frontplane_drive
);

  lcd_state_type state;
  lcd_state_type next_state;

  // ----------------------------------------------------------------
  // Field views of the registers
  // ----------------------------------------------------------------
  logic       clock_source_bus;
  logic       prescale_by_sixteen;
  logic [5:0] clock_adjust_field;
  logic       charge_pump_enable;
  logic       pump_multiplier_select;
  logic [1:0] supply_select;
  logic       wait_mode_off;
  logic       deep_stop_off;
  logic [2:0] frame_clock_select;
  logic [1:0] duty_field;
  logic       blink_enable;
  logic       blink_mode_select;
  logic [2:0] blink_rate_select;
  logic       lcd_run;
  logic       clk_tick;
  logic [9:0] prescale_limit;
  logic [6:0] frame_limit;
  logic [11:0] blink_limit;

  assign clock_source_bus       = state.clock_select[7];
  assign prescale_by_sixteen    = state.clock_select[6];
  assign clock_adjust_field     = state.clock_select[5:0];
  assign charge_pump_enable     = state.supply_control[7];
  assign pump_multiplier_select = state.supply_control[6];
  assign supply_select          = state.supply_control[1:0];
  assign wait_mode_off          = state.low_power[1];
  assign deep_stop_off          = state.low_power[0];
  assign frame_clock_select     = state.frame_control[5:3];
  assign duty_field             = state.frame_control[1:0];
  assign blink_enable           = state.blink_control[7];
  assign blink_mode_select      = state.blink_control[3];
  assign blink_rate_select      = state.blink_control[2:0];

  // Low-power gating of the whole drive
  assign lcd_run = !(state.wait_sync[1] && wait_mode_off)
                && !(state.stop_sync[1] && deep_stop_off);

  // Clock source: one tick per bus clock, or one per external rising edge
  // The external reference is much slower than ref_clk, so an edge detect suffices
  assign clk_tick = clock_source_bus ? 1'b1
                  : (state.ext_sync[1] && !state.ext_sync[2]);

  // Divider limits derived from the programmed fields
  assign prescale_limit = prescale_by_sixteen
                        ? {clock_adjust_field, 4'hF}
                        : {4'h0, clock_adjust_field};
  assign frame_limit = 7'((8'h01 << frame_clock_select) - 8'h01);
  // The shift sum is widened first: a 3-bit sum would wrap past 7 at rate 4
  // and above, turning the slowest rates into the fastest blinks, one per base tick at rate 4
  assign blink_limit = 12'((13'h0001 << ({1'b0, blink_rate_select} + `BLINK_RATE_SHIFT))
                         - 13'h0001);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    // Synchronisers: first stage feeds only the second
    next_state.ext_sync  = {state.ext_sync[1:0], ext_clk_ref};
    next_state.wait_sync = {state.wait_sync[0], wait_mode};
    next_state.stop_sync = {state.stop_sync[0], deep_stop_mode};

    // Register writes
    if (reg_write)
    begin
      unique case (reg_addr)
        `OFS_CLOCK_SELECT:   next_state.clock_select   = reg_wdata;
        `OFS_SUPPLY_CONTROL: next_state.supply_control = reg_wdata;
        `OFS_LOW_POWER:      next_state.low_power      = reg_wdata & `LOW_POWER_MASK;
        `OFS_FRAME_CONTROL:  next_state.frame_control  = reg_wdata & `FRAME_MASK;
        `OFS_BLINK_CONTROL:  next_state.blink_control  = reg_wdata & `BLINK_MASK;
        default:
        begin
          for (int i = 0; i < `FRONTPLANE_REGS; i++)
          begin
            if (reg_addr == 4'(`OFS_FRONTPLANE_BASE + i))
              next_state.frontplane_enable[i*8 +: 8] = reg_wdata;
          end
        end
      endcase
    end

    // Read data stands for one cycle after the strobe, zero otherwise
    next_state.read_data = 8'h00;
    if (reg_read)
    begin
      unique case (reg_addr)
        `OFS_CLOCK_SELECT:   next_state.read_data = state.clock_select;
        `OFS_SUPPLY_CONTROL: next_state.read_data = state.supply_control;
        `OFS_LOW_POWER:      next_state.read_data = state.low_power;
        `OFS_FRAME_CONTROL:  next_state.read_data = state.frame_control;
        `OFS_BLINK_CONTROL:  next_state.read_data = state.blink_control;
        default:
        begin
          for (int i = 0; i < `FRONTPLANE_REGS; i++)
          begin
            if (reg_addr == 4'(`OFS_FRONTPLANE_BASE + i))
              next_state.read_data = state.frontplane_enable[i*8 +: 8];
          end
        end
      endcase
    end

    // Prescaler: base tick every (adjust+1) or 16*(adjust+1) source ticks
    next_state.base_tick = 1'b0;
    if (!lcd_run)
      next_state.prescale_count = 10'h000;
    else if (clk_tick)
    begin
      if (state.prescale_count >= prescale_limit)
      begin
        next_state.prescale_count = 10'h000;
        next_state.base_tick      = 1'b1;
      end
      else
        next_state.prescale_count = state.prescale_count + 10'h001;
    end

    // Frame divider steps the backplane phase; duty sets phase count
    next_state.frame_start = 1'b0;
    // Reprogramming the frame register restarts the phase count, so a smaller
    // duty never leaves the backplane index beyond the new last phase
    if (!lcd_run || (reg_write && reg_addr == `OFS_FRAME_CONTROL))
    begin
      next_state.frame_count = 7'h00;
      next_state.backplane   = 2'h0;
    end
    else if (state.base_tick)
    begin
      if (state.frame_count >= frame_limit)
      begin
        next_state.frame_count = 7'h00;
        if (state.backplane >= duty_field)
        begin
          next_state.backplane   = 2'h0;
          next_state.frame_start = 1'b1;
        end
        else
          next_state.backplane = state.backplane + 2'h1;
      end
      else
        next_state.frame_count = state.frame_count + 7'h01;
    end

    // Blink timer runs on base ticks; it never touches frame timing
    if (!lcd_run || !blink_enable)
    begin
      next_state.blink_count = 12'h000;
      next_state.blink_blank = 1'b0;
    end
    else if (state.base_tick)
    begin
      if (state.blink_count >= blink_limit)
      begin
        next_state.blink_count = 12'h000;
        next_state.blink_blank = !state.blink_blank;
      end
      else
        next_state.blink_count = state.blink_count + 12'h001;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state                   <= '0;
      state.clock_select      <= `REG_RESET;
      state.supply_control    <= `REG_RESET;
      state.low_power         <= `REG_RESET;
      state.frame_control     <= `REG_RESET;
      state.blink_control     <= `REG_RESET;
    end
    else
      state <= next_state;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Supply routing follows the control bits directly; pump on is also gated by lcd_run, tripler by the supply code
  assign reg_rdata         = state.read_data;
  assign lcd_active        = lcd_run;
  assign charge_pump_on    = charge_pump_enable && lcd_run;
  assign pump_tripler      = pump_multiplier_select
                          && (supply_select != `SUPPLY_INTERNAL);
  assign pump_clock_adjust = state.supply_control[4:3];
  assign buffer_bypass     = state.supply_control[2];
  assign supply_internal   = (supply_select == `SUPPLY_INTERNAL);
  assign supply_external   = (supply_select == `SUPPLY_EXTERNAL);
  assign high_drive_buffer = state.supply_control[5];
  assign low_power_wave    = state.frame_control[2];
  assign duty_select       = duty_field;
  assign backplane_index   = state.backplane;
  assign frame_start       = state.frame_start;
  assign base_tick         = state.base_tick;
  // Blank phase hits every segment or only the marked ones
  assign blank_all         = state.blink_blank && blink_mode_select;
  assign blank_selected    = state.blink_blank;
  // Disabled pins stay undriven so they can serve as ordinary I/O
  assign frontplane_drive  = state.frontplane_enable & {48{lcd_run}};

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_wait_keeps_on: assert property (
    (state.wait_sync[1] && !wait_mode_off && !state.stop_sync[1]) |-> lcd_active)
    else $error("LCD dropped in wait mode while allowed on");

  a_stop_turns_off: assert property (
    (state.stop_sync[1] && deep_stop_off) |-> (!lcd_active && frontplane_drive == 48'h0))
    else $error("LCD still driven in deep stop");

  a_pump_enable: assert property (
    charge_pump_on == (charge_pump_enable && lcd_active))
    else $error("Charge pump state mismatch");

  a_pump_mode_internal: assert property (
    (supply_select == `SUPPLY_INTERNAL) |-> !pump_tripler)
    else $error("Tripler selected on internal supply");

  a_supply_routes: assert property (
    !(supply_internal && supply_external))
    else $error("Internal and external supply both selected");

  a_bypass_follows: assert property (
    (reg_write && reg_addr == `OFS_SUPPLY_CONTROL) |=> (buffer_bypass == $past(reg_wdata[2])))
    else $error("Bypass bit not taken from write");

  a_bus_source_tick: assert property (
    (clock_source_bus && lcd_run && !prescale_by_sixteen && clock_adjust_field == 6'h00
      && $stable(state.clock_select) && $past(lcd_run)) |=> base_tick)
    else $error("Base tick missing at divide-by-one");

  a_third_duty_wrap: assert property (
    (duty_field == `DUTY_THIRD) |-> (backplane_index <= 2'h2))
    else $error("Backplane beyond third phase at one-third duty");

  a_frame_on_base: assert property (
    frame_start |-> $past(base_tick))
    else $error("Frame start without base tick");

  a_blink_on_base: assert property (
    $changed(state.blink_blank) && state.blink_blank |-> $past(base_tick))
    else $error("Blink toggle without base tick");

  a_blank_all_mode: assert property (
    blank_all |-> (blink_mode_select && blank_selected))
    else $error("Blank all outside blink-all mode");

  a_read_latency: assert property (
    (reg_read && reg_addr == `OFS_FRONTPLANE_BASE) |=>
      (reg_rdata == $past(state.frontplane_enable[7:0])))
    else $error("Frontplane enable read back wrong");

  a_source_ext: assert property (
    (!clock_source_bus && !(state.ext_sync[1] && !state.ext_sync[2])) |-> !clk_tick)
    else $error("Tick without external edge");

  // ----------------------------------------------------------------
  // Configuration checks
  // ----------------------------------------------------------------
  // Pump enable write reaches the pump output
  a_pump_write: assert property (
    (reg_write && reg_addr == `OFS_SUPPLY_CONTROL && reg_wdata[7])
      |=> (charge_pump_on == lcd_active))
    else $error("Charge pump not on after enable write");

  // Pump mode follows the written bit off the internal supply
  a_tripler_external: assert property (
    (reg_write && reg_addr == `OFS_SUPPLY_CONTROL && reg_wdata[1:0] != `SUPPLY_INTERNAL)
      |=> (pump_tripler == $past(reg_wdata[6])))
    else $error("Pump mode not taken from write");

  // Internal supply code routes the panel internally
  a_supply_internal: assert property (
    (reg_write && reg_addr == `OFS_SUPPLY_CONTROL && reg_wdata[1:0] == `SUPPLY_INTERNAL)
      |=> (supply_internal && !supply_external))
    else $error("Internal supply not selected");

  // External supply code routes the panel to its supply pin
  a_supply_external: assert property (
    (reg_write && reg_addr == `OFS_SUPPLY_CONTROL && reg_wdata[1:0] == `SUPPLY_EXTERNAL)
      |=> (supply_external && !supply_internal))
    else $error("External supply not selected");

  // Pump clock field follows the write
  a_pump_clock_write: assert property (
    (reg_write && reg_addr == `OFS_SUPPLY_CONTROL)
      |=> (pump_clock_adjust == $past(reg_wdata[4:3])))
    else $error("Pump clock adjust not taken from write");

  // Wait with the wait-off bit set stops the drive
  a_wait_turns_off: assert property (
    (state.wait_sync[1] && wait_mode_off) |-> !lcd_active)
    else $error("LCD still driven in wait with wait-off set");

  // Deep stop without the stop-off bit keeps the drive
  a_stop_stays_on: assert property (
    (state.stop_sync[1] && !deep_stop_off && !(state.wait_sync[1] && wait_mode_off))
      |-> lcd_active)
    else $error("LCD dropped in deep stop while allowed on");

  // Base ticks come only from source ticks while running
  a_base_from_source: assert property (
    base_tick |-> ($past(clk_tick) && $past(lcd_run)))
    else $error("Base tick without source tick");

  // A frame always starts on the first backplane
  a_frame_phase_zero: assert property (
    frame_start |-> (backplane_index == 2'h0))
    else $error("Frame start off the first backplane");

  // Backplane phase never passes the duty setting
  a_backplane_in_duty: assert property (
    backplane_index <= duty_field)
    else $error("Backplane beyond the duty setting");

  // Blinking off clears the blank phase
  a_blink_idle: assert property (
    !blink_enable |=> !blank_selected)
    else $error("Blank phase without blinking enabled");

  // Segment mode never blanks everything
  a_blank_only_mode: assert property (
    !blink_mode_select |-> !blank_all)
    else $error("Blank all in segment blink mode");

  // Running drive shows every enabled frontplane
  a_frontplane_gate: assert property (
    lcd_active |-> (frontplane_drive == state.frontplane_enable))
    else $error("Frontplane drive differs from enables");

  // Read data stand only after a read strobe
  a_rdata_idle: assert property (
    !$past(reg_read) |-> (reg_rdata == 8'h00))
    else $error("Read data outside the read cycle");

endmodule

// ---- tb/lcd_glass_model.sv ----
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Segment glass seen from the frontplane and backplane side
// ----------------------------------------------------------------
module lcd_glass_model
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [1:0]  backplane_index,
  input  wire logic        frame_start,
  input  wire logic        blank_selected,
  input  wire logic [47:0] frontplane_drive,
  output int               phases_seen,
  output logic      [47:0] lit_pins
);
  int top;

  // Glass lights only driven pins, and none while the blink phase blanks them
  assign lit_pins = blank_selected ? 48'h0 : frontplane_drive;

  // Highest backplane seen in a frame gives the multiplex depth
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      top <= 0;
      phases_seen <= 0;
    end
    else if (frame_start)
    begin
      phases_seen <= top + 1;
      top <= 0;
    end
    else if (int'(backplane_index) > top)
      top <= int'(backplane_index);
  end
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/100ps
module tb;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic        ext_clk_ref = 1'b0;
  logic        wait_mode = 1'b0;
  logic        deep_stop_mode = 1'b0;
  logic [7:0]  reg_rdata;
  logic        lcd_active, charge_pump_on, pump_tripler, buffer_bypass;
  logic        supply_internal, supply_external, high_drive_buffer, low_power_wave;
  logic [1:0]  pump_clock_adjust, duty_select, backplane_index;
  logic        frame_start, base_tick, blank_all, blank_selected;
  logic [47:0] frontplane_drive, lit_pins;
  int          phases_seen;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          ext_cnt = 0;
  int          g;
  logic [7:0]  d;

  // ----------------------------------------------------------------
  // Clocks and instances
  // ----------------------------------------------------------------
  // 250 MHz reference
  always #2 ref_clk = ~ref_clk;

  // External reference of ten periods, five high and five low, its edges falling on ref_clk rising edges
  always @(posedge ref_clk)
  begin
    ext_cnt <= (ext_cnt + 1) % 10;
    ext_clk_ref <= (ext_cnt < 5);
  end

  lcd_config lcd_config_inst (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .ext_clk_ref(ext_clk_ref), .wait_mode(wait_mode),
    .deep_stop_mode(deep_stop_mode), .lcd_active(lcd_active),
    .charge_pump_on(charge_pump_on), .pump_tripler(pump_tripler),
    .pump_clock_adjust(pump_clock_adjust), .buffer_bypass(buffer_bypass),
    .supply_internal(supply_internal), .supply_external(supply_external),
    .high_drive_buffer(high_drive_buffer), .low_power_wave(low_power_wave),
    .duty_select(duty_select), .backplane_index(backplane_index),
    .frame_start(frame_start), .base_tick(base_tick), .blank_all(blank_all),
    .blank_selected(blank_selected), .frontplane_drive(frontplane_drive));

  lcd_glass_model lcd_glass_model_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .backplane_index(backplane_index), .frame_start(frame_start),
    .blank_selected(blank_selected), .frontplane_drive(frontplane_drive),
    .phases_seen(phases_seen), .lit_pins(lit_pins));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
    begin
      samples_checked++;
      if (seen !== exp)
      begin
        bad_count++;
        $display("Error %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask

  // One strobe cycle; ends at the falling edge of the cycle after it
  task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] v);
    begin
      @(posedge ref_clk);
      reg_write <= w;
      reg_read <= r;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge ref_clk);
      reg_write <= 1'b0;
      reg_read <= 1'b0;
      @(negedge ref_clk);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    bus(1'b1, 1'b0, a, v);
  endtask

  // Read data stand only in the cycle where bus returns
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    begin
      bus(1'b0, 1'b1, a, 8'h00);
      v = reg_rdata;
    end
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: pick = base_tick;
      1: pick = frame_start;
      2: pick = blank_selected;
      default: pick = blank_all;
    endcase
  endfunction

  // Bounded wait for the next rising edge of the picked signal
  task automatic rise(input int sel, inout int n);
    begin
      while (pick(sel) === 1'b1 && n < 3000) @(negedge ref_clk) n++;
      while (pick(sel) !== 1'b1 && n < 3000) @(negedge ref_clk) n++;
    end
  endtask

  task automatic gap_of(input int sel, output int gap);
    int n;
    begin
      n = 0;
      rise(sel, n);
      gap = 0;
      rise(sel, gap);
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    logic [7:0] mask [12] = '{8'hFF, 8'hFF, 8'h03, 8'h3F, 8'h8F, 8'hFF,
                              8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00};
    begin
      chk("lcd_active", lcd_active, 1'b1);
      for (int a = 0; a < 12; a++)
      begin
        rd(a[3:0], d);
        chk("reset value", d, 8'h00);
        wr(a[3:0], 8'hFF);
        rd(a[3:0], d);
        chk("readback", d, mask[a]);
        @(negedge ref_clk);
        chk("rdata idle", reg_rdata, 8'h00);
        wr(a[3:0], 8'h00);
      end
      $display("registers done");
    end
  endtask

  // Supply writes against the packed pump and supply outputs
  task automatic t_supply;
    logic [7:0] w [4] = '{8'h81, 8'hC1, 8'h5E, 8'h20};
    logic [7:0] e [4] = '{8'h84, 8'h84, 8'h7A, 8'h01};
    begin
      for (int i = 0; i < 4; i++)
      begin
        wr(4'h1, w[i]);
        d = {charge_pump_on, pump_tripler, pump_clock_adjust, buffer_bypass,
             supply_internal, supply_external, high_drive_buffer};
        chk("supply", d, e[i]);
      end
      $display("supply done");
    end
  endtask

  task automatic t_clock;
    begin
      wr(4'h0, 8'h82);
      gap_of(0, g);
      chk("bus tick gap", 48'(g), 48'h3);
      wr(4'h0, 8'hC0);
      gap_of(0, g);
      chk("prescale_by_sixteen tick gap", 48'(g), 48'h10);
      wr(4'h0, 8'h00);
      gap_of(0, g);
      chk("ext tick gap", 48'(g), 48'hA);
      $display("clock done");
    end
  endtask

  task automatic t_frame;
    begin
      wr(4'h0, 8'h80);
      wr(4'h3, 8'h02);
      gap_of(1, g);
      chk("frame gap", 48'(g), 48'h3);
      chk("phases", 48'(phases_seen), 48'h3);
      chk("duty", duty_select, 2'h2);
      wr(4'h0, 8'h82);
      wr(4'h3, 8'h1E);
      gap_of(1, g);
      chk("slow frame gap", 48'(g), 48'h48);
      chk("low power wave", low_power_wave, 1'b1);
      $display("frame done");
    end
  endtask

  // 33 frontplanes, then wait and deep-stop gating
  task automatic t_power;
    begin
      for (int a = 5; a < 11; a++)
        wr(a[3:0], (a < 9) ? 8'hFF : (a == 9) ? 8'h01 : 8'h00);
      chk("frontplanes", frontplane_drive, 48'h0001FFFFFFFF);
      wr(4'h2, 8'h01);
      @(posedge ref_clk);
      deep_stop_mode <= 1'b1;
      repeat (4) @(negedge ref_clk);
      chk("stop active", lcd_active, 1'b0);
      chk("stop frontplanes", frontplane_drive, 48'h0);
      @(posedge ref_clk);
      deep_stop_mode <= 1'b0;
      wait_mode <= 1'b1;
      repeat (4) @(negedge ref_clk);
      chk("wait kept on", lcd_active, 1'b1);
      wr(4'h2, 8'h02);
      chk("wait off", lcd_active, 1'b0);
      wr(4'h2, 8'h00);
      chk("wait restored", lcd_active, 1'b1);
      $display("power done");
    end
  endtask

  task automatic t_blink;
    begin
      wr(4'h0, 8'h80);
      wr(4'h3, 8'h02);
      wr(4'h4, 8'h80);
      gap_of(2, g);
      chk("blink gap", 48'(g), 48'h20);
      chk("blank all off", blank_all, 1'b0);
      wr(4'h4, 8'h81);
      gap_of(2, g);
      chk("blink gap rate1", 48'(g), 48'h40);
      // Rate 4 toggles every 256 base ticks
      wr(4'h4, 8'h84);
      gap_of(2, g);
      chk("blink gap rate4", 48'(g), 48'h200);
      wr(4'h4, 8'h88);
      gap_of(3, g);
      chk("blink all gap", 48'(g), 48'h20);
      chk("glass blank", lit_pins, 48'h0);
      wr(4'h4, 8'h00);
      // Blank phase clears one cycle after the write lands
      @(negedge ref_clk);
      chk("blink off", blank_selected, 1'b0);
      chk("glass lit", lit_pins, 48'h0001FFFFFFFF);
      $display("blink done");
    end
  endtask

  task automatic close_out;
    begin
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  // Reset held five cycles, released on a rising edge
  initial
  begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    t_regs;
    t_supply;
    t_clock;
    t_frame;
    t_power;
    t_blink;
    close_out;
  end

  // The run needs a few thousand cycles; twenty thousand means a hang
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    close_out;
  end
endmodule
